// >>> dv/cdsc_dm_model.sv
// debug module model that raises halt requests toward the core
`timescale 1ns/1ps
module cdsc_dm_model
    import cdsc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic halt_cmd_in,
    input wire logic halted_in,
    output logic halt_req_out
);
    logic pend_reg;
    ////////////////////////////////////////////////////////////////////////
    // a request stays up at least one full cycle and drops only once the
    // core shows halted, so a slow core never loses it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_reg <= 1'b0;
        end else if (halt_cmd_in) begin
            pend_reg <= 1'b1;
        end else if (halted_in) begin
            pend_reg <= 1'b0;
        end
    end
    assign halt_req_out = pend_reg;
endmodule : cdsc_dm_model

// >>> dv/tb.sv
// self-checking bench for the core debug state control block
`timescale 1ns/1ps
module tb
    import cdsc_pkg::*;
;
    localparam logic [31:0] HALT_VEC = 32'h0000_0800;
    localparam logic [31:0] TRAP_VEC = 32'h0000_0900;
    localparam logic [31:0] MTVEC_VAL = 32'h0000_0100;
    logic clk = 1'b0, rst_n = 1'b0, permit = 1'b0, halt_cmd = 1'b0;
    logic id_valid = 1'b0, id_ebreak = 1'b0, id_exc = 1'b0, id_dret = 1'b0;
    logic id_retire = 1'b0, irq_taken = 1'b0, we = 1'b0, re = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, id_pc = 32'h0, rdata, target;
    logic halt_req, illegal, kill, pc_set, dbg_mode, haverst, running, halted;
    logic acc_pend = 1'b0, mon_on = 1'b0, saw_run = 1'b0;
    logic [32:0] exp_q[$];
    logic [31:0] rnd_state = 32'hFD8D7475;
    int failures = 0, tests_run = 0, cyc = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    cdsc_debug_ctrl cdsc_debug_ctrl_i (
        .CLK_IN(clk), .RST_N_IN(rst_n), .FETCH_PERMIT_IN(permit),
        .HALT_REQ_IN(halt_req), .HALT_ENTRY_VECTOR_IN(HALT_VEC),
        .DEBUG_TRAP_VECTOR_IN(TRAP_VEC), .MTVEC_IN(MTVEC_VAL),
        .ID_PC_IN(id_pc), .ID_VALID_IN(id_valid), .ID_EBREAK_IN(id_ebreak),
        .ID_EXCEPTION_IN(id_exc), .ID_RETIRE_IN(id_retire),
        .ID_DRET_IN(id_dret),
        .IRQ_TAKEN_IN(irq_taken), .CSR_WE_IN(we), .CSR_RE_IN(re),
        .CSR_ADDR_IN(addr), .CSR_WDATA_IN(wdata), .CSR_RDATA_OUT(rdata),
        .ILLEGAL_OUT(illegal), .ID_KILL_OUT(kill), .PC_SET_OUT(pc_set),
        .PC_TARGET_OUT(target), .DEBUG_MODE_OUT(dbg_mode),
        .HAVERESET_OUT(haverst), .RUNNING_OUT(running), .HALTED_OUT(halted)
    );

    cdsc_dm_model cdsc_dm_model_i (
        .clk_in(clk), .rst_n_in(rst_n), .halt_cmd_in(halt_cmd),
        .halted_in(halted), .halt_req_out(halt_req)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state;
    endfunction : rnd

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // one strobe per call; calls may follow each other with no gap
    task automatic csr(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        we <= w;
        re <= ~w;
        addr <= a;
        wdata <= d;
        exp_q.push_back(e);
    endtask : csr

    task automatic bus_idle();
        @(posedge clk);
        we <= 1'b0;
        re <= 1'b0;
    endtask : bus_idle

    task automatic wait_st(input logic run, input int lim);
        int n;
        n = 0;
        while ((run ? running : halted) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_st

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        permit <= 1'b0;
        repeat (16) @(negedge clk);
        check("in_reset", {haverst, running, halted}, 32'h4);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(negedge clk);
        check("unavail", {haverst, running, halted}, 32'h4);
    endtask : do_reset

    // one decode slot holding an ebreak or a faulting instruction
    task automatic slot(input logic brk, input logic [31:0] p,
                        input logic [31:0] tgt);
        @(posedge clk);
        id_valid <= 1'b1;
        id_ebreak <= brk;
        id_exc <= ~brk;
        id_pc <= p;
        @(posedge clk);
        id_valid <= 1'b0;
        id_ebreak <= 1'b0;
        id_exc <= 1'b0;
        @(negedge clk);
        check("pc_set", pc_set, 32'h1);
        check("pc_target", target, tgt);
    endtask : slot

    // one decode slot holding a return from debug mode
    task automatic resume(input logic [31:0] tgt);
        @(posedge clk);
        id_valid <= 1'b1;
        id_dret <= 1'b1;
        @(posedge clk);
        id_valid <= 1'b0;
        id_dret <= 1'b0;
        @(negedge clk);
        check("resume_target", target, tgt);
        check("resume_state", {running, halted}, 32'h2);
    endtask : resume

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        acc_pend <= we | re;
        cyc <= cyc + 1;
        if (haverst === 1'b1) begin
            saw_run <= 1'b0;
        end else if (running === 1'b1) begin
            saw_run <= 1'b1;
        end
        if (cyc == 5000) begin
            failures++;
            complete_run();
        end
    end

    always @(negedge clk) begin
        if (acc_pend) begin
            check("csr_rdata", rdata, exp_q[0][31:0]);
            check("csr_illegal", illegal, exp_q[0][32]);
            void'(exp_q.pop_front());
        end
        if (mon_on) begin
            check("status_sum", haverst + running + halted, 32'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] dbg_a [4];
        logic [31:0] pc, d, dcsr_v;
        dbg_a = '{CSR_DCSR, CSR_DPC, CSR_DSCRATCH0, CSR_DSCRATCH1};
        repeat (2) @(posedge clk);
        mon_on = 1'b1;
        do_reset();
        @(posedge clk);
        permit <= 1'b1;
        wait_st(1'b1, 8);
        check("run_state", {haverst, running, halted}, 32'h2);
        for (int i = 0; i < 8; i++) begin
            csr(i[0], dbg_a[i/2], rnd(), {1'b1, WORD_ZERO});
        end
        csr(1'b1, CSR_TDATA1, 32'hFFFF_FFFF, {1'b0, WORD_ZERO});
        csr(1'b1, CSR_TDATA2, rnd(), {1'b0, WORD_ZERO});
        csr(1'b0, CSR_TDATA2, 32'h0, {1'b0, WORD_ZERO});
        csr(1'b0, CSR_TDATA1, 32'h0, {1'b0, TDATA1_RESET});
        csr(1'b0, CSR_TINFO, 32'h0, {1'b0, TINFO_VALUE});
        bus_idle();
        pc = rnd() & 32'hFFFF_FFFE;
        slot(1'b1, pc, MTVEC_VAL);
        check("no_debug", {dbg_mode, running}, 32'h1);
        csr(1'b0, CSR_MEPC, 32'h0, {1'b0, pc});
        csr(1'b0, CSR_MCAUSE, 32'h0, {1'b0, MCAUSE_BREAKPOINT});
        bus_idle();
        pc = rnd() & 32'hFFFF_FFFC;
        @(posedge clk);
        id_valid <= 1'b1;
        id_pc <= pc;
        halt_cmd <= 1'b1;
        @(posedge clk);
        halt_cmd <= 1'b0;
        wait_st(1'b0, 6);
        check("halt_state", {running, halted, dbg_mode}, 32'h3);
        check("halt_redirect", {kill, pc_set}, 32'h3);
        check("halt_target", target, HALT_VEC);
        @(posedge clk);
        id_valid <= 1'b0;
        dcsr_v = DCSR_RESET | (32'(CAUSE_HALTREQ) << DCSR_CAUSE_LSB);
        csr(1'b0, CSR_DPC, 32'h0, {1'b0, pc});
        csr(1'b0, CSR_DCSR, 32'h0, {1'b0, dcsr_v});
        dcsr_v[DCSR_EBREAK_BIT] = 1'b1;
        csr(1'b1, CSR_DCSR, dcsr_v, {1'b0, WORD_ZERO});
        csr(1'b0, CSR_DCSR, 32'h0, {1'b0, dcsr_v});
        d = rnd();
        csr(1'b1, CSR_DSCRATCH1, d, {1'b0, WORD_ZERO});
        csr(1'b0, CSR_DSCRATCH1, 32'h0, {1'b0, d});
        d = rnd() & ~(32'h1 << TD1_DEBUG_ONLY_TRIGGER_FIELD_BIT);
        csr(1'b1, CSR_TDATA1, d, {1'b0, WORD_ZERO});
        d = (TDATA1_RESET & ~32'h4) | (d & 32'h4);
        csr(1'b0, CSR_TDATA1, 32'h0, {1'b0, d});
        bus_idle();
        slot(1'b1, rnd() & 32'hFFFF_FFFE, HALT_VEC);
        slot(1'b0, rnd(), TRAP_VEC);
        check("stay_halted", {running, halted}, 32'h1);
        csr(1'b0, CSR_DPC, 32'h0, {1'b0, pc});
        csr(1'b0, CSR_DCSR, 32'h0, {1'b0, dcsr_v});
        bus_idle();
        // resume; scratch is locked again and ebreak now enters debug mode
        resume(pc);
        csr(1'b0, CSR_DSCRATCH1, 32'h0, {1'b1, WORD_ZERO});
        bus_idle();
        pc = (rnd() & 32'hFFFF_FFFC) | 32'h0000_0100;
        slot(1'b1, pc, HALT_VEC);
        check("ebreak_halt", {running, halted}, 32'h1);
        dcsr_v[DCSR_CAUSE_LSB +: 3] = CAUSE_EBREAK;
        csr(1'b0, CSR_DPC, 32'h0, {1'b0, pc});
        csr(1'b0, CSR_DCSR, 32'h0, {1'b0, dcsr_v});
        // single step hit by an interrupt: one handler instruction retires
        dcsr_v[DCSR_STEP_BIT] = 1'b1;
        csr(1'b1, CSR_DCSR, dcsr_v, {1'b0, WORD_ZERO});
        bus_idle();
        resume(pc);
        @(posedge clk);
        irq_taken <= 1'b1;
        @(posedge clk);
        irq_taken <= 1'b0;
        id_retire <= 1'b1;
        pc = rnd() & 32'hFFFF_FFFC;
        id_pc <= pc;
        @(negedge clk);
        check("step_irq_run", {running, halted}, 32'h2);
        @(posedge clk);
        id_retire <= 1'b0;
        @(negedge clk);
        check("step_halt", {running, halted}, 32'h1);
        dcsr_v[DCSR_CAUSE_LSB +: 3] = CAUSE_STEP;
        csr(1'b0, CSR_DPC, 32'h0, {1'b0, pc});
        csr(1'b0, CSR_DCSR, 32'h0, {1'b0, dcsr_v});
        bus_idle();
        // second reset in mid-run; the request now precedes the permit
        do_reset();
        @(posedge clk);
        halt_cmd <= 1'b1;
        @(posedge clk);
        halt_cmd <= 1'b0;
        permit <= 1'b1;
        wait_st(1'b0, 10);
        check("early_halt", {haverst, running, halted}, 32'h1);
        check("never_ran", saw_run, 32'h0);
        complete_run();
    end
endmodule : tb

// >>> logic/cdsc_csr_mem.sv
// small register store for the debug scratch words, registered read data
`timescale 1ns/1ps
module cdsc_csr_mem
    import cdsc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic we_in,
    input wire logic waddr_in,
    input wire logic [31:0] wdata_in,
    input wire logic raddr_in,
    input wire logic re_in,
    output logic [31:0] rdata_out
);
    logic [31:0] mem_reg [2];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_reg[0] <= WORD_ZERO;
            mem_reg[1] <= WORD_ZERO;
            rdata_out <= WORD_ZERO;
        end else begin
            if (we_in) begin
                mem_reg[waddr_in] <= wdata_in;
            end
            // zero unless a granted read, so no word leaks onto the bus
            rdata_out <= re_in ? mem_reg[raddr_in] : WORD_ZERO;
        end
    end
endmodule : cdsc_csr_mem

// >>> logic/cdsc_debug_ctrl.sv
// debug state, status pins, debug/trigger csrs and ebreak handling
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module cdsc_debug_ctrl
    import cdsc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic FETCH_PERMIT_IN,
    input wire logic HALT_REQ_IN,
    input wire logic [31:0] HALT_ENTRY_VECTOR_IN,
    input wire logic [31:0] DEBUG_TRAP_VECTOR_IN,
    input wire logic [31:0] MTVEC_IN,
    input wire logic [31:0] ID_PC_IN,
    input wire logic ID_VALID_IN,
    input wire logic ID_EBREAK_IN,
    input wire logic ID_EXCEPTION_IN,
    input wire logic ID_DRET_IN,
    input wire logic ID_RETIRE_IN,
    input wire logic IRQ_TAKEN_IN,
    input wire logic CSR_WE_IN,
    input wire logic CSR_RE_IN,
    input wire logic [11:0] CSR_ADDR_IN,
    input wire logic [31:0] CSR_WDATA_IN,
    output logic [31:0] CSR_RDATA_OUT,
    output logic ILLEGAL_OUT,
    output logic ID_KILL_OUT,
    output logic PC_SET_OUT,
    output logic [31:0] PC_TARGET_OUT,
    output logic DEBUG_MODE_OUT,
    output logic HAVERESET_OUT,
    output logic RUNNING_OUT,
    output logic HALTED_OUT
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        cdsc_state_t st;
        logic [1:0] cnt;
        logic permit_seen;
        logic req_pending;
        logic [31:0] dcsr;
        logic [31:0] dpc;
        logic [31:0] mepc;
        logic [31:0] mcause;
        logic [31:0] tdata1;
        logic [31:0] tdata2;
        logic [31:0] rdata;
        logic illegal;
        logic kill;
        logic pc_set;
        logic [31:0] pc_target;
        logic havereset;
        logic running;
        logic halted;
    } cdsc_regs_t;

    cdsc_regs_t r_reg;
    cdsc_regs_t r_next;
    logic debug_only_trigger_field;
    logic is_dbg_csr;
    logic is_trig_csr;
    logic scr_we;
    logic scr_re;
    logic scr_sel;
    logic [31:0] scr_rdata;
    logic trig_hit;
    logic halt_now;
    logic [2:0] cause;

    assign debug_only_trigger_field = (r_reg.st == ST_HALT);
    assign is_dbg_csr = (CSR_ADDR_IN == CSR_DCSR) || (CSR_ADDR_IN == CSR_DPC)
        || (CSR_ADDR_IN == CSR_DSCRATCH0) || (CSR_ADDR_IN == CSR_DSCRATCH1);
    assign is_trig_csr = (CSR_ADDR_IN == CSR_TSELECT)
        || (CSR_ADDR_IN == CSR_TDATA1) || (CSR_ADDR_IN == CSR_TDATA2)
        || (CSR_ADDR_IN == CSR_TINFO);
    assign scr_sel = (CSR_ADDR_IN == CSR_DSCRATCH1);
    // scratch writes only take effect in debug mode
    assign scr_we = CSR_WE_IN && debug_only_trigger_field && ((CSR_ADDR_IN == CSR_DSCRATCH0)
        || (CSR_ADDR_IN == CSR_DSCRATCH1));
    assign scr_re = CSR_RE_IN && debug_only_trigger_field && ((CSR_ADDR_IN == CSR_DSCRATCH0)
        || (CSR_ADDR_IN == CSR_DSCRATCH1));
    // one trigger, execute address match only
    assign trig_hit = r_reg.tdata1[TD1_EXEC_BIT] && ID_VALID_IN
        && (ID_PC_IN == r_reg.tdata2);

    cdsc_csr_mem u_scratch (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .we_in(scr_we),
        .waddr_in(scr_sel),
        .wdata_in(CSR_WDATA_IN),
        .raddr_in(scr_sel),
        .re_in(scr_re),
        .rdata_out(scr_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_next = r_reg;
        r_next.illegal = 1'b0;
        r_next.kill = 1'b0;
        r_next.pc_set = 1'b0;
        r_next.rdata = WORD_ZERO;
        halt_now = 1'b0;
        cause = CAUSE_HALTREQ;
        // a request arriving before start is remembered for direct halt
        if (HALT_REQ_IN) begin
            r_next.req_pending = 1'b1;
        end
        // csr reads; scratch data is delivered from the memory register
        if (CSR_RE_IN) begin
            if (is_dbg_csr && !debug_only_trigger_field) begin
                r_next.illegal = 1'b1;
            end else begin
                unique case (CSR_ADDR_IN)
                    CSR_DCSR: r_next.rdata = r_reg.dcsr;
                    CSR_DPC: r_next.rdata = r_reg.dpc;
                    CSR_TSELECT: r_next.rdata = WORD_ZERO;
                    CSR_TDATA1: r_next.rdata = r_reg.tdata1;
                    CSR_TDATA2: r_next.rdata = r_reg.tdata2;
                    CSR_TINFO: r_next.rdata = TINFO_VALUE;
                    CSR_MEPC: r_next.rdata = r_reg.mepc;
                    CSR_MCAUSE: r_next.rdata = r_reg.mcause;
                    default: r_next.rdata = WORD_ZERO;
                endcase
            end
        end
        if (CSR_WE_IN) begin
            if (is_dbg_csr && !debug_only_trigger_field) begin
                r_next.illegal = 1'b1;
            end else if (is_trig_csr && !debug_only_trigger_field) begin
                r_next.illegal = 1'b0;
            end else begin
                unique case (CSR_ADDR_IN)
                    // ebreak bit only changes here, in debug mode
                    CSR_DCSR: r_next.dcsr[DCSR_EBREAK_BIT] =
                        CSR_WDATA_IN[DCSR_EBREAK_BIT];
                    CSR_DPC: r_next.dpc = CSR_WDATA_IN;
                    CSR_TDATA1: r_next.tdata1[TD1_EXEC_BIT] =
                        CSR_WDATA_IN[TD1_EXEC_BIT];
                    CSR_TDATA2: r_next.tdata2 = CSR_WDATA_IN;
                    CSR_MEPC: r_next.mepc = CSR_WDATA_IN;
                    default: r_next.illegal = 1'b0;
                endcase
            end
            // step bit is also writable in debug mode
            if (debug_only_trigger_field && CSR_ADDR_IN == CSR_DCSR) begin
                r_next.dcsr[DCSR_STEP_BIT] = CSR_WDATA_IN[DCSR_STEP_BIT];
            end
        end
        r_next.tdata1[TD1_DEBUG_ONLY_TRIGGER_FIELD_BIT] = 1'b1;

        unique case (r_reg.st)
            ST_RESET: begin
                if (FETCH_PERMIT_IN) begin
                    r_next.permit_seen = 1'b1;
                end
                if (r_reg.permit_seen) begin
                    if (r_reg.cnt == START_DELAY) begin
                        // early request: no running cycle in between
                        if (r_reg.req_pending || HALT_REQ_IN) begin
                            halt_now = 1'b1;
                        end else begin
                            r_next.st = ST_RUN;
                        end
                    end else begin
                        r_next.cnt = r_reg.cnt + CNT_ONE;
                    end
                end
            end
            ST_RUN: begin
                if (HALT_REQ_IN || r_reg.req_pending) begin
                    halt_now = 1'b1;
                end else if (trig_hit) begin
                    halt_now = 1'b1;
                    cause = CAUSE_TRIGGER;
                end else if (ID_VALID_IN && ID_EBREAK_IN
                             && r_reg.dcsr[DCSR_EBREAK_BIT]) begin
                    halt_now = 1'b1;
                    cause = CAUSE_EBREAK;
                end else if (ID_VALID_IN && ID_EBREAK_IN) begin
                    r_next.mepc = ID_PC_IN;
                    r_next.mcause = MCAUSE_BREAKPOINT;
                    r_next.kill = 1'b1;
                    r_next.pc_set = 1'b1;
                    r_next.pc_target = MTVEC_IN;
                end else if (r_reg.dcsr[DCSR_STEP_BIT] && IRQ_TAKEN_IN) begin
                    r_next.st = ST_STEPIRQ;
                end else if (r_reg.dcsr[DCSR_STEP_BIT] && ID_RETIRE_IN) begin
                    halt_now = 1'b1;
                    cause = CAUSE_STEP;
                end
            end
            ST_STEPIRQ: begin
                // let the first handler instruction retire before halting
                if (HALT_REQ_IN || r_reg.req_pending) begin
                    halt_now = 1'b1;
                end else if (ID_RETIRE_IN) begin
                    halt_now = 1'b1;
                    cause = CAUSE_STEP;
                end
            end
            ST_HALT: begin
                r_next.req_pending = 1'b0;
                if (ID_VALID_IN && ID_EBREAK_IN) begin
                    r_next.kill = 1'b1;
                    r_next.pc_set = 1'b1;
                    r_next.pc_target = HALT_ENTRY_VECTOR_IN;
                end else if (ID_VALID_IN && ID_EXCEPTION_IN) begin
                    r_next.kill = 1'b1;
                    r_next.pc_set = 1'b1;
                    r_next.pc_target = DEBUG_TRAP_VECTOR_IN;
                end else if (ID_VALID_IN && ID_DRET_IN) begin
                    // resume at the saved pc
                    r_next.st = ST_RUN;
                    r_next.kill = 1'b1;
                    r_next.pc_set = 1'b1;
                    r_next.pc_target = r_reg.dpc;
                end
            end
        endcase

        if (halt_now) begin
            r_next.st = ST_HALT;
            r_next.dpc = ID_PC_IN;
            r_next.dcsr[DCSR_CAUSE_LSB +: 3] = cause;
            r_next.kill = 1'b1;
            r_next.pc_set = 1'b1;
            r_next.pc_target = HALT_ENTRY_VECTOR_IN;
            r_next.req_pending = 1'b0;
        end

        // status pins: one-hot by construction
        r_next.havereset = (r_next.st == ST_RESET);
        r_next.halted = (r_next.st == ST_HALT);
        r_next.running = !r_next.havereset && !r_next.halted;
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r_reg <= '0;
            r_reg.st <= ST_RESET;
            r_reg.dcsr <= DCSR_RESET;
            r_reg.tdata1 <= TDATA1_RESET;
            r_reg.havereset <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign CSR_RDATA_OUT = r_reg.rdata | scr_rdata;
    assign ILLEGAL_OUT = r_reg.illegal;
    assign ID_KILL_OUT = r_reg.kill;
    assign PC_SET_OUT = r_reg.pc_set;
    assign PC_TARGET_OUT = r_reg.pc_target;
    assign DEBUG_MODE_OUT = r_reg.halted;
    assign HAVERESET_OUT = r_reg.havereset;
    assign RUNNING_OUT = r_reg.running;
    assign HALTED_OUT = r_reg.halted;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_halt_req_running;
        RUNNING_OUT && HALT_REQ_IN;
    endsequence
    sequence s_halt_reached;
        ##[1:3] HALTED_OUT;
    endsequence

    property p_one_hot;
        $onehot({HAVERESET_OUT, RUNNING_OUT, HALTED_OUT});
    endproperty
    a_one_hot: assert property (p_one_hot)
        else $error("status outputs not one-hot");

    property p_halt_in_time;
        s_halt_req_running |-> s_halt_reached;
    endproperty
    a_halt_in_time: assert property (p_halt_in_time)
        else $error("halt request while running not honoured");

    property p_debug_only_trigger_field_trig;
        r_reg.tdata1[TD1_DEBUG_ONLY_TRIGGER_FIELD_BIT];
    endproperty
    a_debug_only_trigger_field_trig: assert property (p_debug_only_trigger_field_trig)
        else $error("trigger debug-only field not 1");

    property p_illegal_csr;
        (CSR_RE_IN && is_dbg_csr && !debug_only_trigger_field) |=> ILLEGAL_OUT;
    endproperty
    a_illegal_csr: assert property (p_illegal_csr)
        else $error("debug csr access outside debug mode not illegal");

    property p_trig_write_ignored;
        (CSR_WE_IN && CSR_ADDR_IN == CSR_TDATA2 && !debug_only_trigger_field)
            |=> $stable(r_reg.tdata2);
    endproperty
    a_trig_write_ignored: assert property (p_trig_write_ignored)
        else $error("trigger written outside debug mode");

    property p_early_req_direct;
        (HAVERESET_OUT && HALT_REQ_IN) |=> (!RUNNING_OUT) [*3];
    endproperty
    a_early_req_direct: assert property (p_early_req_direct)
        else $error("running shown despite early halt request");

    property p_ebreak_trap;
        (r_reg.st == ST_RUN && ID_VALID_IN && ID_EBREAK_IN && !HALT_REQ_IN
            && !r_reg.req_pending && !trig_hit
            && !r_reg.dcsr[DCSR_EBREAK_BIT])
            |=> PC_SET_OUT && PC_TARGET_OUT == $past(MTVEC_IN)
            && RUNNING_OUT && r_reg.mepc == $past(ID_PC_IN);
    endproperty
    a_ebreak_trap: assert property (p_ebreak_trap)
        else $error("ebreak did not trap to machine vector");

    property p_ebreak_in_debug;
        (HALTED_OUT && ID_VALID_IN && ID_EBREAK_IN)
            |=> PC_TARGET_OUT == $past(HALT_ENTRY_VECTOR_IN)
            && HALTED_OUT && $stable(r_reg.dpc);
    endproperty
    a_ebreak_in_debug: assert property (p_ebreak_in_debug)
        else $error("ebreak in debug mode misbehaved");

    property p_ebreak_to_debug_bit_locked;
        !debug_only_trigger_field |=> $stable(r_reg.dcsr[DCSR_EBREAK_BIT]);
    endproperty
    a_ebreak_to_debug_bit_locked: assert property (p_ebreak_to_debug_bit_locked)
        else $error("ebreak-to-debug bit changed outside debug mode");
endmodule : cdsc_debug_ctrl

// >>> logic/cdsc_pkg.sv
// constants, state type and encodings for the core debug state control block
package cdsc_pkg;
    localparam int XLEN = 32;
    localparam int CSR_AW = 12;
    // csr addresses of the debug, trigger and machine trap registers
    localparam logic [11:0] CSR_TSELECT = 12'h7A0;
    localparam logic [11:0] CSR_TDATA1 = 12'h7A1;
    localparam logic [11:0] CSR_TDATA2 = 12'h7A2;
    localparam logic [11:0] CSR_TINFO = 12'h7A4;
    localparam logic [11:0] CSR_DCSR = 12'h7B0;
    localparam logic [11:0] CSR_DPC = 12'h7B1;
    localparam logic [11:0] CSR_DSCRATCH0 = 12'h7B2;
    localparam logic [11:0] CSR_DSCRATCH1 = 12'h7B3;
    localparam logic [11:0] CSR_MEPC = 12'h341;
    localparam logic [11:0] CSR_MCAUSE = 12'h342;
    // field positions
    localparam int DCSR_EBREAK_BIT = 15;
    localparam int DCSR_CAUSE_LSB = 6;
    localparam int DCSR_STEP_BIT = 2;
    localparam int TD1_DEBUG_ONLY_TRIGGER_FIELD_BIT = 27;
    localparam int TD1_EXEC_BIT = 2;
    // reset and fixed values
    localparam logic [31:0] DCSR_RESET = 32'h4000_0003;
    localparam logic [31:0] TDATA1_RESET = 32'h2800_1000;
    localparam logic [31:0] TINFO_VALUE = 32'h0000_0004;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // debug entry causes
    localparam logic [2:0] CAUSE_EBREAK = 3'h1;
    localparam logic [2:0] CAUSE_TRIGGER = 3'h2;
    localparam logic [2:0] CAUSE_HALTREQ = 3'h3;
    localparam logic [2:0] CAUSE_STEP = 3'h4;
    // exception causes
    localparam logic [31:0] MCAUSE_BREAKPOINT = 32'h0000_0003;
    // counter value that ends the unavailable state; leaving it takes four cycles after fetch permit
    localparam logic [1:0] START_DELAY = 2'h2;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_ZERO = 2'h0;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN = 2'b01,
        ST_HALT = 2'b11,
        ST_STEPIRQ = 2'b10
    } cdsc_state_t;
endpackage : cdsc_pkg
